// ### verilog/timer_unit_core.sv
// Timer unit core: prescaled 16-bit counter, modulo, overflow, two channels.
// Assumes a classic Wishbone master and system wait/stop/break levels.
// Contract
// - Match modulo sets overflow, counter restarts zero
// - Overflow flag and enable raise interrupt
// - Channel event sets flag, enable gates interrupt
// - Wait mode keeps counting, blocks access, wakes
// - Stop mode freezes counter, prescaler and captures, keeps state
// - Break freezes counter, inhibits captures
// - Break without clear-enable protects flags
// - Break with clear-enable allows flag clearing
// - Overflow clear is read then write zero
// - Halt bit stops counter, reset sets it
// - Halt bit inhibits input captures
// - Clear bit zeroes counter and prescaler
// - Halt plus clear holds counter at zero
// - Prescale field divides bus clock 1..64
// - High byte read latches low byte
// - Reset and clear zero counter bytes
// - Modulo high write suppresses overflow until low
// - Reset sets modulo to all ones
// - Channels capture or compare, channel 0 buffered bit acts as plain compare
// - Channel flag clear is read then write zero
// - Mode bits select capture or compare
// - Channel high write suppresses compares until low
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "timer_unit_params.svh"
module timer_unit_core import timer_unit_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System state levels
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic breakActive,
  // Channel capture pins
  input wire logic [1:0] capturePin,
  // Interrupt requests
  output logic overflowIrq,
  output logic [1:0] channelIrq,
  output logic wakeReq
);
  busReq_t bus;
  logic ack_q, req, rdReq, wr, clrAllowed, running, tick, wrapHit, ovfEvent;
  logic ovfClr, cntClr, ovf_q, ovfIe_q, ovfArm_q, halt_q, breakClearEn_q;
  logic modHold_q, latched_q, irqLvl;
  logic [2:0] ps_q;
  logic [5:0] pre_q, preMask;
  logic [7:0] datOut_q, readData, cntLatch_q;
  logic [15:0] cnt_q, mod_q;
  logic [1:0] chIrqLvl, capEv, chFlag;
  logic [7:0] chRdData [2];
  assign bus = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 dat: wb_dat_i[7:0], sel0: wb_sel_i[0]};
  // Reads act at the request edge so the latched low byte matches the high
  assign req = bus.cyc & bus.stb & ~ack_q;
  // Registers are out of reach of the CPU in wait mode: zero, no effect
  assign rdReq = req & ~bus.we & ~waitMode;
  assign wr = bus.cyc & bus.stb & ack_q & bus.we & bus.sel0 & ~waitMode;
  assign clrAllowed = ~breakActive | breakClearEn_q;
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus.cyc & bus.stb & ~ack_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      datOut_q <= 8'h00;
    end else if (req) begin
      datOut_q <= (bus.we | waitMode) ? 8'h00 : readData;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, datOut_q};
  // Prescaler and counter
  assign running = ~halt_q & ~breakActive & ~stopMode;
  assign preMask = 6'h3f >> (`PRESCALE_TOP - ps_q);
  assign tick = running & (ps_q != `PRESCALE_NONE)
                & ((pre_q & preMask) == preMask);
  assign wrapHit = (cnt_q == mod_q);
  assign ovfEvent = tick & wrapHit & ~modHold_q;
  assign cntClr = wr & (bus.adr == `OFS_STATUS_CTL) & bus.dat[`POS_CLR];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pre_q <= 6'h00;
    end else if (cntClr) begin
      pre_q <= 6'h00;
    end else if (running) begin
      pre_q <= pre_q + 6'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_q <= `COUNT_RST;
    end else if (cntClr) begin
      cnt_q <= `COUNT_RST;
    end else if (tick) begin
      cnt_q <= wrapHit ? `COUNT_RST : cnt_q + 16'h0001;
    end
  end

  // Low-byte holding buffer for coherent 16-bit reads
  always_ff @(posedge clock) begin
    if (!rstn || cntClr) begin
      latched_q <= 1'b0;
      cntLatch_q <= 8'h00;
    end else if (rdReq && bus.adr == `OFS_COUNT_HIGH && !latched_q) begin
      latched_q <= 1'b1;
      cntLatch_q <= cnt_q[7:0];
    end else if (rdReq && bus.adr == `OFS_COUNT_LOW) begin
      latched_q <= 1'b0;
    end
  end

  // Modulo limit; software should clear the counter first or a wrap is missed
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mod_q <= `MODULO_RST;
      modHold_q <= 1'b0;
    end else if (wr && bus.adr == `OFS_MODULO_HIGH) begin
      mod_q[15:8] <= bus.dat;
      modHold_q <= 1'b1;
    end else if (wr && bus.adr == `OFS_MODULO_LOW) begin
      mod_q[7:0] <= bus.dat;
      modHold_q <= 1'b0;
    end
  end

  // Control fields of the status register
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovfIe_q <= 1'b0;
      halt_q <= `HALT_RST;
      ps_q <= `PRESCALE_RST;
    end else if (wr && bus.adr == `OFS_STATUS_CTL) begin
      ovfIe_q <= bus.dat[`POS_OVF_IE];
      halt_q <= bus.dat[`POS_HALT];
      ps_q <= bus.dat[`POS_PS_HI:`POS_PS_LO];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      breakClearEn_q <= 1'b0;
    end else if (wr && bus.adr == `OFS_BREAK_CTL) begin
      breakClearEn_q <= bus.dat[`POS_BREAK_CLEAR_ENABLE];
    end
  end

  // Two-step overflow clear; a new overflow voids the armed step
  assign ovfClr = wr & (bus.adr == `OFS_STATUS_CTL) & ~bus.dat[`POS_OVF]
                  & ovfArm_q & clrAllowed;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovfArm_q <= 1'b0;
    end else if (ovfEvent || ovfClr) begin
      ovfArm_q <= 1'b0;
    end else if (rdReq && bus.adr == `OFS_STATUS_CTL && ovf_q && clrAllowed) begin
      ovfArm_q <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else if (ovfEvent) begin
      ovf_q <= 1'b1;
    end else if (ovfClr) begin
      ovf_q <= 1'b0;
    end
  end
  // Channels
  for (genvar i = 0; i < 2; i++) begin : chan
    localparam logic [7:0] OFS = `OFS_CHAN_BASE + 8'(i) * `OFS_CHAN_STEP;
    chanCtl_t ctl_q;
    logic [15:0] val_q;
    logic arm_q, cmpHold_q, pinMeta_q, pinSync_q, pinPrev_q;
    logic isCapture, isCompare, cmpEv, event_w, clr;
    // Mode bits: zero selects capture when an edge is enabled, a set bit selects compare
    assign isCapture = ~ctl_q.bufMode & ~ctl_q.unbufMode
                       & (ctl_q.edgeLevel != 2'b00);
    assign isCompare = ctl_q.bufMode | ctl_q.unbufMode;
    assign capEv[i] = isCapture & ~halt_q & ~breakActive & ~stopMode
                      & ((ctl_q.edgeLevel[0] & pinSync_q & ~pinPrev_q)
                      | (ctl_q.edgeLevel[1] & ~pinSync_q & pinPrev_q));
    assign cmpEv = isCompare & ~cmpHold_q & tick & (cnt_q == val_q);
    assign event_w = capEv[i] | cmpEv;
    assign clr = wr & (bus.adr == OFS) & ~bus.dat[`POS_CH_FLAG] & arm_q
                 & clrAllowed;

    always_ff @(posedge clock) begin
      if (!rstn) begin
        pinMeta_q <= 1'b0;
        pinSync_q <= 1'b0;
        pinPrev_q <= 1'b0;
      end else begin
        pinMeta_q <= capturePin[i];
        pinSync_q <= pinMeta_q;
        pinPrev_q <= pinSync_q;
      end
    end

    always_ff @(posedge clock) begin
      if (!rstn) begin
        ctl_q <= '0;
      end else begin
        if (wr && bus.adr == OFS) begin
          ctl_q.irqEn <= bus.dat[6];
          // Only channel 0 has the buffered mode bit
          ctl_q.bufMode <= (i == 0) ? bus.dat[5] : 1'b0;
          ctl_q.unbufMode <= bus.dat[4];
          ctl_q.edgeLevel <= bus.dat[3:2];
          ctl_q.togOvf <= bus.dat[1];
          ctl_q.maxDuty <= bus.dat[0];
        end
        if (event_w) begin
          ctl_q.flag <= 1'b1;
        end else if (clr) begin
          ctl_q.flag <= 1'b0;
        end
      end
    end

    always_ff @(posedge clock) begin
      if (!rstn) begin
        arm_q <= 1'b0;
      end else if (event_w || clr) begin
        arm_q <= 1'b0;
      end else if (rdReq && bus.adr == OFS && ctl_q.flag && clrAllowed) begin
        arm_q <= 1'b1;
      end
    end

    always_ff @(posedge clock) begin
      if (!rstn) begin
        val_q <= 16'h0000;
        cmpHold_q <= 1'b0;
      end else if (capEv[i]) begin
        val_q <= cnt_q;
      end else if (wr && bus.adr == OFS + `OFS_CHAN_VAL_HIGH) begin
        val_q[15:8] <= bus.dat;
        cmpHold_q <= isCompare;
      end else if (wr && bus.adr == OFS + `OFS_CHAN_VAL_LOW) begin
        val_q[7:0] <= bus.dat;
        cmpHold_q <= 1'b0;
      end
    end

    assign chFlag[i] = ctl_q.flag;
    assign chIrqLvl[i] = ctl_q.flag & ctl_q.irqEn;
    assign chRdData[i] = (bus.adr == OFS) ? ctl_q
                       : (bus.adr == OFS + `OFS_CHAN_VAL_HIGH) ? val_q[15:8]
                       : (bus.adr == OFS + `OFS_CHAN_VAL_LOW) ? val_q[7:0]
                       : 8'h00;
  end
  // Read decode; unmapped addresses read zero
  always_comb begin
    readData = 8'h00;
    if (bus.adr == `OFS_STATUS_CTL) begin
      readData = {ovf_q, ovfIe_q, halt_q, 1'b0, 1'b0, ps_q};
    end else if (bus.adr == `OFS_COUNT_HIGH) begin
      readData = cnt_q[15:8];
    end else if (bus.adr == `OFS_COUNT_LOW) begin
      readData = latched_q ? cntLatch_q : cnt_q[7:0];
    end else if (bus.adr == `OFS_MODULO_HIGH) begin
      readData = mod_q[15:8];
    end else if (bus.adr == `OFS_MODULO_LOW) begin
      readData = mod_q[7:0];
    end else if (bus.adr == `OFS_BREAK_CTL) begin
      readData = {7'h00, breakClearEn_q};
    end else begin
      readData = chRdData[0] | chRdData[1];
    end
  end

  // Registered requests; wake needs an enabled request while waiting
  assign irqLvl = (ovf_q & ovfIe_q) | (|chIrqLvl);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      overflowIrq <= 1'b0;
      channelIrq <= 2'b00;
      wakeReq <= 1'b0;
    end else begin
      overflowIrq <= ovf_q & ovfIe_q;
      channelIrq <= chIrqLvl;
      wakeReq <= waitMode & irqLvl;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_wrap;
    tick && wrapHit && !cntClr |=> cnt_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_ovfIrq;
    ovf_q && ovfIe_q |=> overflowIrq;
  endproperty
  a_ovfIrq: assert property (p_ovfIrq) else $error("overflow irq missing");

  property p_chIrq;
    !chFlag[0] |=> !channelIrq[0];
  endproperty
  a_chIrq: assert property (p_chIrq) else $error("spurious channel irq");

  property p_stopFreeze;
    stopMode && !cntClr |=> $stable(cnt_q) && $stable(pre_q);
  endproperty
  a_stopFreeze: assert property (p_stopFreeze) else $error("stop moved");

  property p_breakNoCap;
    breakActive |-> capEv == 2'b00;
  endproperty
  a_breakNoCap: assert property (p_breakNoCap) else $error("break capture");

  property p_protect;
    breakActive && !breakClearEn_q && ovf_q |=> ovf_q;
  endproperty
  a_protect: assert property (p_protect) else $error("flag lost in break");

  property p_newOvfVoids;
    ovfEvent |=> ovf_q && !ovfArm_q;
  endproperty
  a_newOvfVoids: assert property (p_newOvfVoids) else $error("arm kept");

  property p_halt;
    halt_q && !cntClr |=> $stable(cnt_q);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");

  property p_clear;
    cntClr |=> cnt_q == 16'h0000 && pre_q == 6'h00 && !latched_q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_modHold;
    modHold_q |=> !$rose(ovf_q);
  endproperty
  a_modHold: assert property (p_modHold) else $error("overflow during hold");

  property p_waitCount;
    waitMode && tick && !wrapHit && !cntClr |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_waitCount: assert property (p_waitCount) else $error("wait stalled");
  c_overflow: cover property (ovfEvent ##[1:20] ovfClr);
  c_capture: cover property (capEv[0] ##[1:50] chIrqLvl[0]);
  c_latch: cover property (latched_q ##[1:10] !latched_q);
endmodule : timer_unit_core

// ### verilog/timer_unit_params.svh
// Offsets, field positions, reset values and counts of the timer unit.
// Assumes byte-wide registers in the low lane of a 32-bit Wishbone word.
`ifndef TIMER_UNIT_PARAMS_SVH
`define TIMER_UNIT_PARAMS_SVH
`define OFS_STATUS_CTL 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_MODULO_HIGH 8'h0c
`define OFS_MODULO_LOW 8'h10
`define OFS_CHAN_BASE 8'h14
`define OFS_CHAN_STEP 8'h0c
`define OFS_CHAN_VAL_HIGH 8'h04
`define OFS_CHAN_VAL_LOW 8'h08
`define OFS_BREAK_CTL 8'h2c
`define POS_OVF 7
`define POS_OVF_IE 6
`define POS_HALT 5
`define POS_CLR 4
`define POS_PS_HI 2
`define POS_PS_LO 0
`define POS_CH_FLAG 7
`define POS_BREAK_CLEAR_ENABLE 0
`define HALT_RST 1'b1
`define PRESCALE_RST 3'h0
`define PRESCALE_NONE 3'h7
`define PRESCALE_TOP 3'h6
`define MODULO_RST 16'hffff
`define COUNT_RST 16'h0000
`endif

// ### verilog/timer_unit_pkg.sv
// Types shared by the timer unit.
// Assumes the params header is compiled alongside.
package timer_unit_pkg;
  typedef struct packed {
    logic flag;
    logic irqEn;
    logic bufMode;
    logic unbufMode;
    logic [1:0] edgeLevel;
    logic togOvf;
    logic maxDuty;
  } chanCtl_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [7:0] dat;
    logic sel0;
  } busReq_t;
endpackage : timer_unit_pkg

// ### verif/wb_cpu_model.sv
// CPU stand-in: issues classic Wishbone single cycles to the timer unit.
// Assumes the caller enters access just after a rising clock edge.
`timescale 1ns/1ps
module wb_cpu_model (
  // Clock
  input wire logic clock,
  // Wishbone master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [31:0] datO,
  output logic [3:0] sel,
  input wire logic [31:0] datI,
  input wire logic ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    datO = 32'h0;
    sel = 4'h0;
  end

  // Request held whole until ack is sampled; a hang is left to the watchdog
  task access(input logic w, input logic [7:0] a, input logic [7:0] d,
              output logic [7:0] r);
    r = 8'hxx;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datO <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clock);
    end while (ack !== 1'b1);
    r = datI[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data lines flip so stale values cannot pass for fresh ones
    datO <= ~datO;
    @(posedge clock);
  endtask : access
endmodule : wb_cpu_model

// ### verif/timer_counter_core_with_interrupts_test.sv
// Self-checking bench for the timer unit core.
// Assumes the CPU model as bus master and the design's params header.
`timescale 1ns/1ps
`include "timer_unit_params.svh"
module timer_counter_core_with_interrupts_test import timer_unit_pkg::*;;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic waitMode = 1'b0;
  logic stopMode = 1'b0;
  logic breakActive = 1'b0;
  logic [1:0] capturePin = 2'b00;
  wire cyc, stb, we, ack, ovfIrq, wake;
  wire [7:0] adr;
  wire [31:0] datW, datR;
  wire [3:0] sel;
  wire [1:0] chIrq;
  int err_total = 0;
  int total_checks = 0;

  always #50 clock = ~clock;

  wb_cpu_model CPU (.clock(clock), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .datO(datW), .sel(sel), .datI(datR), .ack(ack));

  timer_unit_core DUT (.clock(clock), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(datW),
    .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack),
    .waitMode(waitMode), .stopMode(stopMode),
    .breakActive(breakActive), .capturePin(capturePin),
    .overflowIrq(ovfIrq), .channelIrq(chIrq), .wakeReq(wake));

  function logic [7:0] sts(input logic f, e, h, input logic [2:0] p);
    return {f, e, h, 2'b00, p};
  endfunction : sts

  // Ticks expected over the run window, plus the access overhead
  function int expCount(input int k);
    return ((8 << k) + 3) >> k;
  endfunction : expCount

  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    CPU.access(1'b1, a, d, r);
  endtask : wr

  task rd(input logic [7:0] a, output logic [7:0] r);
    CPU.access(1'b0, a, 8'h00, r);
  endtask : rd

  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chkBit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask : chkBit

  task waitOvf;
    int n;
    n = 0;
    while (ovfIrq !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
  endtask : waitOvf

  task pulse(input int ch);
    @(posedge clock) capturePin[ch] <= 1'b1;
    repeat (6) @(posedge clock);
    capturePin[ch] <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : pulse

  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // Run needs well under 5000 cycles; this allows four times that
  initial begin
    #(20000 * 100);
    err_total++;
    end_sim();
  end

  initial begin
    logic [7:0] v, a, m, c, cfg;
    logic [1:0] e;
    int k, seed;
    seed = $urandom(32'hc435);
    m = 8'($urandom_range(40, 12));
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(0, 0, 1, 0));
    rd(`OFS_MODULO_HIGH, v);
    chk(v, 8'hff);
    rd(`OFS_MODULO_LOW, v);
    chk(v, 8'hff);
    repeat (20) @(posedge clock);
    rd(`OFS_COUNT_LOW, v);
    chk(v, 8'h00);
    rd(8'hfc, v);
    chk(v, 8'h00);
    for (k = 0; k < 7; k++) begin
      wr(`OFS_STATUS_CTL, 8'h30);
      rd(`OFS_COUNT_LOW, v);
      chk(v, 8'h00);
      rd(`OFS_STATUS_CTL, v);
      chk(v, sts(0, 0, 1, 0));
      wr(`OFS_STATUS_CTL, sts(0, 0, 0, 3'(k)));
      repeat (8 << k) @(posedge clock);
      wr(`OFS_STATUS_CTL, sts(0, 0, 1, 3'(k)));
      rd(`OFS_COUNT_HIGH, v);
      rd(`OFS_COUNT_LOW, v);
      chk(v, 8'(expCount(k)));
    end
    wr(`OFS_STATUS_CTL, 8'h30);
    wr(`OFS_MODULO_HIGH, 8'h00);
    wr(`OFS_MODULO_LOW, m);
    wr(`OFS_STATUS_CTL, sts(0, 1, 0, 0));
    waitOvf();
    chkBit(ovfIrq, 1'b1);
    wr(`OFS_STATUS_CTL, sts(1, 1, 1, 0));
    rd(`OFS_COUNT_LOW, v);
    chkBit(v <= m, 1'b1);
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(1, 1, 1, 0));
    wr(`OFS_STATUS_CTL, sts(0, 1, 1, 0));
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(0, 1, 1, 0));
    chkBit(ovfIrq, 1'b0);
    rd(`OFS_COUNT_LOW, a);
    rd(`OFS_COUNT_HIGH, v);
    wr(`OFS_STATUS_CTL, sts(0, 0, 0, 0));
    repeat (5) @(posedge clock);
    rd(`OFS_COUNT_LOW, v);
    chk(v, a);
    for (k = 0; k < 2; k++) begin
      @(posedge clock) {stopMode, breakActive} <= k[0] ? 2'b10 : 2'b01;
      rd(`OFS_COUNT_LOW, a);
      repeat (9) @(posedge clock);
      rd(`OFS_COUNT_LOW, v);
      {stopMode, breakActive} <= 2'b00;
      chk(v, a);
    end
    wr(`OFS_STATUS_CTL, sts(0, 1, 0, 0));
    waitOvf();
    wr(`OFS_STATUS_CTL, sts(1, 1, 1, 0));
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(1, 1, 1, 0));
    breakActive <= 1'b1;
    wr(`OFS_STATUS_CTL, sts(0, 1, 1, 0));
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(1, 1, 1, 0));
    breakActive <= 1'b0;
    wr(`OFS_STATUS_CTL, sts(0, 1, 1, 0));
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(0, 1, 1, 0));
    wr(`OFS_BREAK_CTL, 8'h01);
    wr(`OFS_STATUS_CTL, sts(0, 1, 0, 0));
    waitOvf();
    wr(`OFS_STATUS_CTL, sts(1, 1, 1, 0));
    breakActive <= 1'b1;
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(1, 1, 1, 0));
    wr(`OFS_STATUS_CTL, sts(0, 1, 1, 0));
    breakActive <= 1'b0;
    rd(`OFS_STATUS_CTL, v);
    chk(v, sts(0, 1, 1, 0));
    wr(`OFS_BREAK_CTL, 8'h00);
    wr(`OFS_STATUS_CTL, 8'h70);
    wr(`OFS_MODULO_HIGH, 8'h00);
    // Counter must run through the limit while the low byte is pending
    wr(`OFS_STATUS_CTL, 8'h50);
    repeat (3 * m) @(posedge clock);
    chkBit(ovfIrq, 1'b0);
    wr(`OFS_MODULO_LOW, m);
    wr(`OFS_STATUS_CTL, 8'h50);
    waitOvf();
    chkBit(ovfIrq, 1'b1);
    waitMode <= 1'b1;
    repeat (3) @(posedge clock);
    chkBit(wake, 1'b1);
    rd(`OFS_MODULO_LOW, v);
    waitMode <= 1'b0;
    chk(v, 8'h00);
    rd(`OFS_STATUS_CTL, v);
    wr(`OFS_STATUS_CTL, sts(0, 0, 1, 0));
    for (k = 0; k < 2; k++) begin
      c = 8'(`OFS_CHAN_BASE + k * `OFS_CHAN_STEP);
      e = {$urandom_range(1, 0) == 1, 1'b1};
      cfg = {1'b0, k == 0, 2'b00, e, 2'b00};
      wr(c, cfg);
      pulse(k);
      rd(c, v);
      chk(v, cfg);
      wr(`OFS_STATUS_CTL, sts(0, 0, 0, 0));
      pulse(k);
      rd(c, v);
      chk(v, cfg | 8'h80);
      chkBit(chIrq[k], k == 0);
      wr(c, cfg);
      rd(c, v);
      chk(v, cfg);
      wr(`OFS_STATUS_CTL, sts(0, 0, 1, 0));
    end
    // Channel 0 as software compare; high byte alone must hold compares off
    wr(`OFS_CHAN_BASE, 8'h10);
    wr(`OFS_CHAN_BASE + `OFS_CHAN_VAL_HIGH, 8'h00);
    wr(`OFS_STATUS_CTL, sts(0, 0, 0, 0));
    repeat (2 * m) @(posedge clock);
    rd(`OFS_CHAN_BASE, v);
    chk(v, 8'h10);
    a = 8'($urandom_range(11, 1));
    wr(`OFS_CHAN_BASE + `OFS_CHAN_VAL_LOW, a);
    repeat (2 * m) @(posedge clock);
    rd(`OFS_CHAN_BASE, v);
    chk(v, 8'h90);
    end_sim();
  end
endmodule : timer_counter_core_with_interrupts_test
